// *** hdl/bridge_out_modes.sv ***
// output-mode logic: steered and full-bridge mapping of one PWM onto four drives
`default_nettype none
module bridge_out_modes
   import bridge_out_pkg::*;
(
   input  wire logic                      CLK_IN,
   input  wire logic                      SRST_IN,
   input  wire logic                      PWM_IN,
   input  wire logic [MODE_W-1:0]         MODE_SELECT_FIELD_IN,
   input  wire logic [STEER_W-1:0]        OUTPUT_STEERING_REG_IN,
   input  wire logic                      STEER_WRITE_IN,
   input  wire logic [DB_W-1:0]           DEADBAND_COUNT_IN,
   output logic                           DRIVE_OUT_A_OUT,
   output logic                           DRIVE_OUT_B_OUT,
   output logic                           DRIVE_OUT_C_OUT,
   output logic                           DRIVE_OUT_D_OUT
);
   import bridge_out_pkg::*;

   // ----------------------------------------------------------------
   // mode decoding
   // ----------------------------------------------------------------
   function automatic logic mode_is_sync(input logic [MODE_W-1:0] m);
      return mode_t'(m) == MODE_SYNC_STEER;
   endfunction

   function automatic logic mode_is_fwd(input logic [MODE_W-1:0] m);
      return mode_t'(m) == MODE_FWD_BRIDGE;
   endfunction

   function automatic logic mode_is_rev(input logic [MODE_W-1:0] m);
      return mode_t'(m) == MODE_REV_BRIDGE;
   endfunction

   // codes above the two bridge modes are spare and drive nothing
   function automatic logic mode_is_bridge(input logic [MODE_W-1:0] m);
      return mode_is_fwd(m) || mode_is_rev(m);
   endfunction

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic pwm_meta_ff;
   logic pwm_sync_ff;
   logic pwm_prev_ff;
   logic rise_evt;

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         pwm_meta_ff <= 1'b0;
         pwm_sync_ff <= 1'b0;
         pwm_prev_ff <= 1'b0;
      end else begin
         pwm_meta_ff <= PWM_IN;
         pwm_sync_ff <= pwm_meta_ff;
         pwm_prev_ff <= pwm_sync_ff;
      end
   end

   // rising event of the synchronised input releases a pending steering change
   assign rise_evt = pwm_sync_ff && !pwm_prev_ff;

   // ----------------------------------------------------------------
   // steering registers
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0] steer_en_ff;
   logic [NUM_OUT-1:0] steer_dat_ff;
   logic [NUM_OUT-1:0] pend_en_ff;
   logic               pend_ff;
   logic [NUM_OUT-1:0] wr_en;
   logic               is_sync;

   assign wr_en   = OUTPUT_STEERING_REG_IN[STEER_EN +: NUM_OUT];
   assign is_sync = mode_is_sync(MODE_SELECT_FIELD_IN);

   // static levels are never synchronised
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         steer_dat_ff <= STEER_RST[STEER_DAT +: NUM_OUT];
      end else if (STEER_WRITE_IN) begin
         steer_dat_ff <= OUTPUT_STEERING_REG_IN[STEER_DAT +: NUM_OUT];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         pend_en_ff <= STEER_RST[STEER_EN +: NUM_OUT];
         pend_ff    <= 1'b0;
      // a newer write replaces a change that is still pending
      end else if (STEER_WRITE_IN && is_sync) begin
         pend_en_ff <= wr_en;
         pend_ff    <= 1'b1;
      end else if (pend_ff && (rise_evt || !is_sync)) begin
         pend_ff    <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         steer_en_ff <= STEER_RST[STEER_EN +: NUM_OUT];
      end else if (STEER_WRITE_IN && !is_sync) begin
         steer_en_ff <= wr_en;
      // leaving sync steering applies the pending routing at once
      end else if (pend_ff && (rise_evt || !is_sync)) begin
         steer_en_ff <= pend_en_ff;
      end
   end

   // ----------------------------------------------------------------
   // full-bridge direction and dead-band
   // ----------------------------------------------------------------
   logic dir_rev_ff;
   logic bridge_on_ff;
   logic is_bridge;
   logic is_rev;
   logic dir_change;
   logic mod_pwm;
   logic mod_gated;

   assign is_rev     = mode_is_rev(MODE_SELECT_FIELD_IN);
   assign is_bridge  = mode_is_bridge(MODE_SELECT_FIELD_IN);
   assign dir_change = is_bridge && bridge_on_ff && (is_rev != dir_rev_ff);
   // the delay stage output is one cycle late, so in the cycle of the turn
   // the new leg would still carry the old leg's phase: blank it there
   assign mod_gated  = mod_pwm && !(dir_change && DEADBAND_COUNT_IN != '0);

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         dir_rev_ff   <= 1'b0;
         bridge_on_ff <= 1'b0;
      end else begin
         // leaving the bridge modes forgets the turn: re-entry adds no delay
         bridge_on_ff <= is_bridge;
         if (is_bridge) begin
            dir_rev_ff <= is_rev;
         end
      end
   end

   deadband_delay #(
      .W (DB_W)
   ) u_deadband (
      .clk_in     (CLK_IN),
      .srst_in    (SRST_IN),
      .restart_in (dir_change),
      .count_in   (DEADBAND_COUNT_IN),
      .sig_in     (pwm_sync_ff),
      .sig_out    (mod_pwm)
   );

   // ----------------------------------------------------------------
   // output mapping
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0] drv_ff;
   logic [NUM_OUT-1:0] nxt_drv;
   logic [NUM_OUT-1:0] steer_drv;
   logic               pwm_d1_ff;

   // full-bridge pattern: one leg held fully on, the opposite leg modulated
   function automatic logic [NUM_OUT-1:0] bridge_map(input logic rev, input logic mod);
      logic [NUM_OUT-1:0] pat;
      pat = '0;
      if (rev) begin
         pat[OUT_C] = 1'b1;
         pat[OUT_B] = mod;
      end else begin
         pat[OUT_A] = 1'b1;
         pat[OUT_D] = mod;
      end
      return pat;
   endfunction

   // align the steered path to the delay stage latency
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         pwm_d1_ff <= 1'b0;
      end else begin
         pwm_d1_ff <= pwm_sync_ff;
      end
   end

   // each steered output carries the delayed phase or its static level
   for (genvar g = 0; g < NUM_OUT; g++) begin : g_steer
      assign steer_drv[g] = steer_en_ff[g] ? pwm_d1_ff : steer_dat_ff[g];
   end

   always_comb begin
      nxt_drv = '0;
      unique case (mode_t'(MODE_SELECT_FIELD_IN))
         MODE_STEER, MODE_SYNC_STEER: begin
            nxt_drv = steer_drv;
         end
         MODE_FWD_BRIDGE: begin
            nxt_drv = bridge_map(1'b0, mod_gated);
         end
         MODE_REV_BRIDGE: begin
            nxt_drv = bridge_map(1'b1, mod_gated);
         end
         default: begin
            // spare mode codes leave every drive off
            nxt_drv = '0;
         end
      endcase
   end

   // registered drives keep decode glitches off the gate pins
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         drv_ff <= '0;
      end else begin
         drv_ff <= nxt_drv;
      end
   end

   assign DRIVE_OUT_A_OUT = drv_ff[OUT_A];
   assign DRIVE_OUT_B_OUT = drv_ff[OUT_B];
   assign DRIVE_OUT_C_OUT = drv_ff[OUT_C];
   assign DRIVE_OUT_D_OUT = drv_ff[OUT_D];
endmodule // bridge_out_modes
`default_nettype wire

// *** hdl/bridge_out_pkg.sv ***
// constants and types for the steered / full-bridge output mode block
`default_nettype none
package bridge_out_pkg;
   localparam int MODE_W  = 3;
   localparam int NUM_OUT = 4;
   localparam int DB_W    = 8;
   // steering register layout: [3:0] enables, [7:4] static levels
   localparam int STEER_W   = 8;
   localparam int STEER_EN  = 0;
   localparam int STEER_DAT = 4;
   localparam logic [STEER_W-1:0] STEER_RST = 8'h00;
   localparam int OUT_A = 0;
   localparam int OUT_B = 1;
   localparam int OUT_C = 2;
   localparam int OUT_D = 3;
   localparam logic [DB_W-1:0] DB_DEFAULT = 8'h04;

   typedef enum logic [MODE_W-1:0] {
      MODE_STEER      = 3'h0,
      MODE_SYNC_STEER = 3'h1,
      MODE_FWD_BRIDGE = 3'h2,
      MODE_REV_BRIDGE = 3'h3
   } mode_t;
endpackage : bridge_out_pkg
`default_nettype wire

// *** hdl/deadband_delay.sv ***
// holds a signal low for a programmable count of cycles after a restart; otherwise passes it one cycle late
`default_nettype none
module deadband_delay
   import bridge_out_pkg::*;
#(
   parameter int W = DB_W
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic         restart_in,
   input  wire logic [W-1:0] count_in,
   input  wire logic         sig_in,
   output logic              sig_out
);
   logic [W-1:0] cnt_ff;
   logic         busy_ff;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else if (restart_in && count_in != '0) begin
         cnt_ff  <= count_in;
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff  <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
         if (cnt_ff == {{(W-1){1'b0}}, 1'b1}) begin
            busy_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sig_out <= 1'b0;
      end else begin
         sig_out <= sig_in && !busy_ff && !(restart_in && count_in != '0);
      end
   end
endmodule // deadband_delay
`default_nettype wire

// *** verif/bridge_gate_model.sv ***
// gate driver model of the bridge legs
`default_nettype none
module bridge_gate_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] gate_in,
   output logic            shoot_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] h1_ff;
   logic [3:0] h2_ff;
   // high sides a and c keep conducting two cycles after their drive drops
   wire  [3:0] cond = gate_in | ((h1_ff | h2_ff) & 4'h5);
   always_ff @(posedge clk_in) begin
      h1_ff <= gate_in;
      h2_ff <= h1_ff;
   end
   assign shoot_out = (cond[0] & cond[1]) | (cond[2] & cond[3]);
endmodule // bridge_gate_model
`default_nettype wire

// *** verif/bridge_out_checker.sv ***
// port assertions of the bridge output mode block
`default_nettype none
module bridge_out_checker
   import bridge_out_pkg::*;
(
   input wire logic               CLK_IN,
   input wire logic               SRST_IN,
   input wire logic               PWM_IN,
   input wire logic [MODE_W-1:0]  MODE_SELECT_FIELD_IN,
   input wire logic [STEER_W-1:0] OUTPUT_STEERING_REG_IN,
   input wire logic               STEER_WRITE_IN,
   input wire logic [DB_W-1:0]    DEADBAND_COUNT_IN,
   input wire logic               DRIVE_OUT_A_OUT,
   input wire logic               DRIVE_OUT_B_OUT,
   input wire logic               DRIVE_OUT_C_OUT,
   input wire logic               DRIVE_OUT_D_OUT
);
   wire  [2:0] m = MODE_SELECT_FIELD_IN;
   wire  [3:0] o = {DRIVE_OUT_D_OUT, DRIVE_OUT_C_OUT, DRIVE_OUT_B_OUT, DRIVE_OUT_A_OUT};
   logic [2:0] last_ff;
   logic [7:0] age_ff;
   // cycles the mode has held, saturating
   wire  [7:0] age = (m == last_ff) ? age_ff : 8'h00;
   always_ff @(posedge CLK_IN) begin
      last_ff <= m;
      age_ff  <= SRST_IN ? 8'h00 : age + {7'h00, age != 8'hFF};
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   sequence s_turn;
      m == 3'h3 && last_ff == 3'h2 && DEADBAND_COUNT_IN >= 8'h03;
   endsequence
   sequence s_fix;
      m == 3'h0 && STEER_WRITE_IN && !OUTPUT_STEERING_REG_IN[0] ##1 m == 3'h0;
   endsequence
   property p_rst; $fell(SRST_IN) |-> o == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("drives high after reset");
   property p_fwd; m == 3'h2 && age > 8'h01 |-> o[2:0] == 3'h1; endproperty
   a_fwd: assert property (p_fwd) else $error("forward levels");
   property p_fpwm; m == 3'h2 && age > DEADBAND_COUNT_IN + 8 |-> o[3] == $past(PWM_IN, 4); endproperty
   a_fpwm: assert property (p_fpwm) else $error("forward pwm");
   property p_rev; m == 3'h3 && age > 8'h01 |-> {o[3], o[2], o[0]} == 3'h2; endproperty
   a_rev: assert property (p_rev) else $error("reverse levels");
   property p_rpwm; m == 3'h3 && age > DEADBAND_COUNT_IN + 8 |-> o[1] == $past(PWM_IN, 4); endproperty
   a_rpwm: assert property (p_rpwm) else $error("reverse pwm");
   property p_db; s_turn |-> !o[1] [*3]; endproperty
   a_db: assert property (p_db) else $error("no dead-band");
   sequence s_back;
      m == 3'h2 && last_ff == 3'h3 && DEADBAND_COUNT_IN >= 8'h03;
   endsequence
   property p_db_back; s_back |-> !o[3] [*3]; endproperty
   a_db_back: assert property (p_db_back) else $error("no dead-band on return");
   property p_fix; s_fix |-> ##1 o[0] == $past(OUTPUT_STEERING_REG_IN[4], 2); endproperty
   a_fix: assert property (p_fix) else $error("static level late");
   property p_off; m[2] && age > 8'h01 |-> o == 4'h0; endproperty
   a_off: assert property (p_off) else $error("spare mode drives");
endmodule // bridge_out_checker
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench of the bridge output mode block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'h0, rst = 1'h1, pwm = 1'h0, wr = 1'h0, watch = 1'h0;
   logic [2:0]  md = 3'h0;
   logic [7:0]  st = 8'h00, db = 8'h06;
   logic [31:0] v;
   logic [3:0]  q[$];
   wire         shoot;
   wire  [3:0]  o;
   int          errors = 0, checks_done = 0, cyc = 0;
   event        look;
   always #20 clk = ~clk;
   bridge_out_modes bridge_out_modes_inst (.CLK_IN(clk), .SRST_IN(rst), .PWM_IN(pwm), .MODE_SELECT_FIELD_IN(md),
      .OUTPUT_STEERING_REG_IN(st), .STEER_WRITE_IN(wr), .DEADBAND_COUNT_IN(db), .DRIVE_OUT_A_OUT(o[0]),
      .DRIVE_OUT_B_OUT(o[1]), .DRIVE_OUT_C_OUT(o[2]), .DRIVE_OUT_D_OUT(o[3]));
   bridge_gate_model bridge_gate_model_inst (.clk_in(clk), .gate_in(o), .shoot_out(shoot));
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic expect_o(input logic [3:0] e);
      q.push_back(e);
      ->look;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr_st(input logic [7:0] x);
      st = x;
      wr = 1'h1;
      tick(1);
      wr = 1'h0;
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(look) check("drives", o, q.pop_front());
   always @(negedge clk) if (watch) check("shoot", {3'h0, shoot}, 4'h0);
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      v = $urandom(32'h07407798);
      tick(12);
      rst = 1'h0;
      expect_o(4'h0);
      for (int i = 0; i < 8; i++) begin
         v = $urandom;
         md = {2'h0, v[8]};
         wr_st({v[7:4], 4'h0});
         tick(2);
         expect_o(v[7:4]);
      end
      md = 3'h0;
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         pwm = v[8];
         wr_st(v[7:0]);
         tick(6);
         expect_o((v[3:0] & {4{v[8]}}) | (v[7:4] & ~v[3:0]));
      end
      for (int i = 0; i < 2; i++) begin
         pwm = 1'h0;
         // clear the enables while still in plain mode so they apply at once
         wr_st(8'hF0);
         md = 3'(i);
         tick(6);
         wr_st(8'hFF);
         tick(2);
         expect_o(i ? 4'hF : 4'h0);
         pwm = 1'h1;
         tick(6);
         expect_o(4'hF);
         pwm = 1'h0;
         tick(6);
         expect_o(4'h0);
      end
      for (int i = 2; i < 8; i++)
         for (int p = 0; p < 2; p++) begin
            md = 3'(i);
            pwm = p[0];
            tick(20);
            expect_o(i == 2 ? {p[0], 3'h1} : i == 3 ? {2'h1, p[0], 1'h0} : 4'h0);
         end
      watch = 1'h1;
      pwm = 1'h1;
      for (int i = 0; i < 2; i++) begin
         md = 3'(2 + i);
         tick(20);
         md = 3'(3 - i);
         tick(3);
         expect_o(i ? 4'h1 : 4'h4);
         tick(12);
         expect_o(i ? 4'h9 : 4'h6);
      end
      for (int i = 0; i < 300; i++) begin
         v = $urandom;
         pwm = v[0];
         md = 3'(2 + i / 60 % 2);
         tick(1);
      end
      finish_test();
   end
endmodule // tb_top
bind bridge_out_modes bridge_out_checker bridge_out_checker_inst (.*);
`default_nettype wire
